// file: verilog/rst_seq_params.svh
// Timing and filter constants for the supply and pushbutton reset sequencer.
// Assumes a 25 MHz MCLK; all counts are derived from times in their own units.
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS       40
`define UV_FILTER_NS        13000
`define UV_FILTER_CYC       ((`UV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFT_PULSE_US       100
`define SOFT_PULSE_CYC      ((`SOFT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define DEBOUNCE_MS         20
`define DEBOUNCE_CYC        ((`DEBOUNCE_MS * 1000000) / `CLK_PERIOD_NS)
`define LONG_PRESS_S        2
`define LONG_PRESS_CYC      ((`LONG_PRESS_S * 1000000000) / `CLK_PERIOD_NS)
`define RESET_PERIOD_MS     200
`define RESET_PERIOD_CYC    ((`RESET_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define CNT_W               26

`endif

// file: verilog/rst_seq_pkg.sv
// Types shared by the reset sequencer.
// Assumes the constants header is included by the design file.
package rst_seq_pkg;

    typedef enum logic [3:0] {
        PB_IDLE     = 4'b0001,
        PB_HELD     = 4'b0010,
        PB_DEBOUNCE = 4'b0100,
        PB_PULSE    = 4'b1000
    } pb_state_t;

    // Raw comparator results, high means the supply is below its threshold
    typedef struct packed {
        logic high_rail_uv;
        logic low_rail_uv;
        logic adj_rail_uv;
    } uv_in_t;

    // Strap detector results for the high-rail override
    typedef struct packed {
        logic rails_match;
        logic above_override;
    } strap_in_t;

endpackage : rst_seq_pkg

// file: verilog/supply_and_pushbutton_reset.sv
// Reset sequencer: supply undervoltage filtering, pushbutton soft and long
// press reset, reset period timing. Assumes comparator and strap detector
// results arrive synchronous to MCLK; pad pull-up is modelled in logic.
// CE low freezes every counter and flag, so time stops with it.
//
// Operation
// - Filter undervoltage for about 13 us.
// - Undriven pushbutton reads as released.
// - Short press gives 100 us soft pulse.
// - Soft pulse starts 20 ms after release.
// - Long press asserts reset, clears period counter.
// - Reset holds 200 ms after button release.
// - Supply reset blocks soft reset output.
// - Held button extends supply reset until release.
// - Strapped below 4.15 V ignores high rail.
// - Strapped above 4.15 V honours high rail.
// - Strapped mid range is a valid supply.
// - Strapped above 4.15 V monitors high rail.
// - Reset until 200 ms after supplies valid.
// - Active-high reset mirrors reset line inverted.
`include "rst_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none

module supply_and_pushbutton_reset
    import rst_seq_pkg::*;
#(
    parameter logic [`CNT_W-1:0] DEBOUNCE_CYC   = `CNT_W'(`DEBOUNCE_CYC),
    parameter logic [`CNT_W-1:0] LONG_PRESS_CYC = `CNT_W'(`LONG_PRESS_CYC),
    parameter logic [`CNT_W-1:0] RESET_CYC      = `CNT_W'(`RESET_PERIOD_CYC)
) (
    input  wire logic      MCLK,
    input  wire logic      RST_N,
    input  wire logic      CE,
    input  wire uv_in_t    UV_IN,
    input  wire strap_in_t STRAP_IN,
    input  wire logic      PUSHBUTTON_IN_N,
    input  wire logic      PUSHBUTTON_IN_OE,
    input  wire logic      RESET_LINE_IN_N,
    output logic           RESET_OUT_N,
    output logic           RESET_OUT_N_OE,
    output logic           RESET_OUT,
    output logic           SOFT_RESET_OUT_N,
    output logic           SOFT_RESET_OUT_N_OE
);

    // ------------------------------------------------------------
    // Pushbutton input
    // ------------------------------------------------------------
    logic      pb_raw;
    logic      pb_meta_r;
    logic      pb_sync_r;

    // Floating pin reads high, as the internal pull-up would make it
    assign pb_raw = PUSHBUTTON_IN_OE ? PUSHBUTTON_IN_N : 1'b1;

    // Two flops; only the second is read by the logic
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pb_meta_r <= 1'b1;
            pb_sync_r <= 1'b1;
        end else if (CE) begin
            pb_meta_r <= pb_raw;
            pb_sync_r <= pb_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Undervoltage filters
    // ------------------------------------------------------------
    localparam int UVW = $clog2(`UV_FILTER_CYC + 1);
    localparam logic [UVW-1:0] UV_CYC = UVW'(`UV_FILTER_CYC);

    logic [2:0] uv_raw;
    logic [2:0] uv_filt;
    logic       high_rail_masked;
    logic       low_rail_masked;

    // Strapped rails below the override level drop the high-rail result;
    // above it the high-rail comparator decides and the low rail is dropped.
    always_comb begin
        high_rail_masked = 1'b0;
        low_rail_masked  = 1'b0;
        unique case ({STRAP_IN.rails_match, STRAP_IN.above_override})
            2'b10: begin
                high_rail_masked = 1'b1;
            end
            2'b11: begin
                low_rail_masked = 1'b1;
            end
            2'b00,
            2'b01: begin
                // No strap seen: every rail counts
                high_rail_masked = 1'b0;
                low_rail_masked  = 1'b0;
            end
        endcase
    end

    assign uv_raw = {UV_IN.high_rail_uv && !high_rail_masked,
                     UV_IN.low_rail_uv && !low_rail_masked,
                     UV_IN.adj_rail_uv};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_uv
            logic [UVW-1:0] cnt_r;
            logic           filt_r;
            logic           flip;

            // Symmetric filter: a glitch shorter than the window is ignored either way
            assign flip = (uv_raw[i] != filt_r) && (cnt_r == UV_CYC - UVW'(1));

            always_ff @(posedge MCLK) begin
                if (!RST_N) begin
                    cnt_r <= '0;
                end else if (CE) begin
                    if ((uv_raw[i] == filt_r) || flip) begin
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + UVW'(1);
                    end
                end
            end

            // Starts out bad so the reset period runs once after power-up
            always_ff @(posedge MCLK) begin
                if (!RST_N) begin
                    filt_r <= 1'b1;
                end else if (CE && flip) begin
                    filt_r <= uv_raw[i];
                end
            end

            assign uv_filt[i] = filt_r;
        end
    endgenerate

    logic supply_bad;
    assign supply_bad = |uv_filt;

    // ------------------------------------------------------------
    // Pushbutton state machine
    // ------------------------------------------------------------
    pb_state_t        pb_state_r;
    logic [`CNT_W-1:0] pb_cnt_r;
    logic             long_press_r;
    logic             supply_rst_r;

    localparam logic [`CNT_W-1:0] PULSE_CYC = `CNT_W'(`SOFT_PULSE_CYC);

    // Set at the end of a long press, dropped once the button is seen released
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            long_press_r <= 1'b0;
        end else if (CE) begin
            if (pb_state_r == PB_HELD) begin
                if (pb_sync_r) begin
                    long_press_r <= 1'b0;
                end else if (pb_cnt_r == LONG_PRESS_CYC - `CNT_W'(1)) begin
                    long_press_r <= 1'b1;
                end
            end
        end
    end

    // One press is handled at a time; a press during a pulse is ignored

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pb_state_r   <= PB_IDLE;
            pb_cnt_r     <= '0;
        end else if (CE) begin
            unique case (pb_state_r)
                PB_IDLE: begin
                    pb_cnt_r <= '0;
                    if (!pb_sync_r) begin
                        pb_state_r <= PB_HELD;
                    end
                end
                PB_HELD: begin
                    if (pb_sync_r) begin
                        pb_cnt_r <= '0;
                        if (long_press_r) begin
                            pb_state_r <= PB_IDLE;
                        end else begin
                            pb_state_r <= PB_DEBOUNCE;
                        end
                    end else if (!long_press_r && (pb_cnt_r != LONG_PRESS_CYC - `CNT_W'(1))) begin
                        pb_cnt_r <= pb_cnt_r + `CNT_W'(1);
                    end
                end
                PB_DEBOUNCE: begin
                    // Bounce restarts the wait instead of making more pulses
                    if (!pb_sync_r) begin
                        pb_cnt_r <= '0;
                    end else if (pb_cnt_r == DEBOUNCE_CYC - `CNT_W'(1)) begin
                        pb_cnt_r   <= '0;
                        pb_state_r <= PB_PULSE;
                    end else begin
                        pb_cnt_r <= pb_cnt_r + `CNT_W'(1);
                    end
                end
                PB_PULSE: begin
                    // A supply reset cancels a pending pulse rather than letting it out late
                    if (supply_rst_r || supply_bad) begin
                        pb_cnt_r   <= '0;
                        pb_state_r <= PB_IDLE;
                    end else if (pb_cnt_r == PULSE_CYC - `CNT_W'(1)) begin
                        pb_cnt_r   <= '0;
                        pb_state_r <= PB_IDLE;
                    end else begin
                        pb_cnt_r <= pb_cnt_r + `CNT_W'(1);
                    end
                end
                default: begin
                    pb_state_r <= PB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reset period counter
    // ------------------------------------------------------------
    logic [`CNT_W-1:0] rst_cnt_r;
    logic             sys_rst_r;
    logic             hold_rst;

    // Long press holds until release; a press held through a supply reset
    // also holds until release.
    assign hold_rst = supply_bad || long_press_r
                   || (!pb_sync_r && sys_rst_r);

    logic rst_done;
    assign rst_done = (rst_cnt_r == RESET_CYC - `CNT_W'(1));

    // Cleared while idle so every reset gets a full period
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rst_cnt_r <= '0;
        end else if (CE) begin
            if (hold_rst || !sys_rst_r) begin
                rst_cnt_r <= '0;
            end else if (!rst_done) begin
                rst_cnt_r <= rst_cnt_r + `CNT_W'(1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sys_rst_r <= 1'b1;
        end else if (CE) begin
            if (hold_rst) begin
                sys_rst_r <= 1'b1;
            end else if (rst_done) begin
                sys_rst_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic soft_r;

    // Remembers a supply reset until its period ends; gates the soft pulse

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            supply_rst_r <= 1'b1;
        end else if (CE) begin
            if (supply_bad) begin
                supply_rst_r <= 1'b1;
            end else if (!sys_rst_r) begin
                supply_rst_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            soft_r <= 1'b0;
        end else if (CE) begin
            // The processor may watch this line rather than wire it to reset
            soft_r <= (pb_state_r == PB_PULSE) && !supply_rst_r && !supply_bad;
        end
    end

    // Open-drain: pin only ever driven low
    assign RESET_OUT_N         = 1'b0;
    assign RESET_OUT_N_OE      = sys_rst_r;
    assign SOFT_RESET_OUT_N    = 1'b0;
    assign SOFT_RESET_OUT_N_OE = soft_r;
    // Follows the resolved line so other OR-tied sources show here too
    assign RESET_OUT           = !RESET_LINE_IN_N;

endmodule : supply_and_pushbutton_reset

`default_nettype wire

// file: testbench/rst_seq_checker.sv
// Port checker for the reset sequencer.
// Counts freeze while CE is low, so they are enabled MCLK cycles.
`timescale 1ns/100ps
`default_nettype none
module rst_seq_checker
    import rst_seq_pkg::*;
#(
    parameter int DEBOUNCE_CYC   = 20,
    parameter int LONG_PRESS_CYC = 100,
    parameter int RESET_CYC      = 50
) (
    input wire logic      MCLK,
    input wire logic      RST_N,
    input wire logic      CE,
    input wire uv_in_t    UV_IN,
    input wire strap_in_t STRAP_IN,
    input wire logic      PUSHBUTTON_IN_N,
    input wire logic      PUSHBUTTON_IN_OE,
    input wire logic      RESET_LINE_IN_N,
    input wire logic      RESET_OUT,
    input wire logic      RESET_OUT_N_OE,
    input wire logic      SOFT_RESET_OUT_N_OE
);
    // --------
    // Helper counts
    // --------
    logic prs, bad;
    int   hi_c, ok_c, bad_c, pr_c, sw_c;
    assign prs = PUSHBUTTON_IN_OE && !PUSHBUTTON_IN_N;
    // Strap decides which rail result counts
    assign bad = UV_IN.adj_rail_uv || (UV_IN.high_rail_uv && !(STRAP_IN.rails_match && !STRAP_IN.above_override))
                 || (UV_IN.low_rail_uv && !(STRAP_IN.rails_match && STRAP_IN.above_override));
    always_ff @(posedge MCLK) begin
        if (!RST_N || CE) begin
            hi_c  <= (!RST_N || prs) ? 0 : hi_c + 1;
            ok_c  <= (!RST_N || prs || bad) ? 0 : ok_c + 1;
            bad_c <= (!RST_N || !bad) ? 0 : bad_c + 1;
            pr_c  <= (!RST_N || !prs) ? 0 : pr_c + 1;
            sw_c  <= (!RST_N || !SOFT_RESET_OUT_N_OE) ? 0 : sw_c + 1;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    line_mirror_a: assert property (RESET_OUT == !RESET_LINE_IN_N)
        else $error("mirror");
    glitch_free_a: assert property ($rose(RESET_OUT_N_OE) |-> bad_c >= 325 || pr_c >= LONG_PRESS_CYC)
        else $error("reset without cause");
    uv_reset_a: assert property (bad_c == 330 |-> RESET_OUT_N_OE)
        else $error("supply reset missing");
    long_press_a: assert property (pr_c == LONG_PRESS_CYC + 6 |-> RESET_OUT_N_OE)
        else $error("long press reset missing");
    reset_hold_a: assert property ($fell(RESET_OUT_N_OE) |-> ok_c >= RESET_CYC)
        else $error("reset released early");
    soft_width_a: assert property ($fell(SOFT_RESET_OUT_N_OE) |-> sw_c == 2500)
        else $error("soft width");
    soft_delay_a: assert property ($rose(SOFT_RESET_OUT_N_OE) |-> hi_c inside {[DEBOUNCE_CYC+2:DEBOUNCE_CYC+6]})
        else $error("soft delay");
    soft_blocked_a: assert property ($rose(SOFT_RESET_OUT_N_OE) |-> !RESET_OUT_N_OE)
        else $error("soft during reset");
endmodule : rst_seq_checker
`default_nettype wire

// file: testbench/reset_far_end.sv
// Far side: pulled-up reset wires and a processor.
// Assumes wires are pulled low only under enable.
`timescale 1ns/100ps
`default_nettype none
module reset_far_end (
    input  wire logic drv_oe,
    input  wire logic soft_oe,
    output logic      line_n,
    output var int    soft_seen
);
    // --------
    // Wires
    // --------
    assign line_n = drv_oe ? 1'b0 : 1'b1;
    initial soft_seen = 0;
    // Processor counts soft requests itself
    always @(posedge soft_oe) soft_seen++;
endmodule : reset_far_end
`default_nettype wire

// file: testbench/tb_supply_and_pushbutton_reset.sv
// Queue-scored bench for the reset sequencer.
// Assumes short counts; CE is held high except in the clock enable test.
`timescale 1ns/100ps
`default_nettype none
module tb_supply_and_pushbutton_reset;
    import rst_seq_pkg::*;
    localparam int DEB = 20, LNG = 100, RPD = 50;
    logic        mclk = 0, rst_n = 0, pb_n = 1, pb_oe = 1, ce = 1, line_n, oe, soft_oe, hi, od_n, sod_n;
    uv_in_t      uv = '0;
    strap_in_t   strap = '0;
    int          errors = 0, num_checks = 0, soft_seen;
    logic [31:0] seed = 32'h6;
    logic [1:0]  expq[$], prev = 2'b10;
    // --------
    // Wiring
    // --------
    supply_and_pushbutton_reset #(.DEBOUNCE_CYC(26'(DEB)), .LONG_PRESS_CYC(26'(LNG)), .RESET_CYC(26'(RPD))) dut_u (
        .MCLK(mclk), .RST_N(rst_n), .CE(ce), .UV_IN(uv), .STRAP_IN(strap), .PUSHBUTTON_IN_N(pb_n),
        .PUSHBUTTON_IN_OE(pb_oe), .RESET_LINE_IN_N(line_n), .RESET_OUT_N(od_n), .RESET_OUT_N_OE(oe),
        .RESET_OUT(hi), .SOFT_RESET_OUT_N(sod_n), .SOFT_RESET_OUT_N_OE(soft_oe));
    reset_far_end far_u (.drv_oe(oe), .soft_oe(soft_oe), .line_n(line_n), .soft_seen(soft_seen));
    initial forever #20 mclk = ~mclk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic press(int n);
        pb_n = 0;
        cyc(n);
        pb_n = 1;
    endtask : press
    task automatic test_done();
        check("pending", 2'(expq.size()), 2'd0);
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Each output change takes the oldest note
    always @(negedge mclk) if (rst_n && {oe, soft_oe} !== prev) begin
        prev = {oe, soft_oe};
        check("high reset", {1'b0, hi}, {1'b0, ~line_n});
        check("drive levels", {od_n, sod_n}, 2'b00);
        if (expq.size() == 0) check("extra", prev, ~prev);
        else check("outputs", prev, expq.pop_front());
    end
    initial begin
        #(40 * 30000);
        $display("BAD watchdog expected end seen hang");
        errors++;
        test_done();
    end
    initial begin
        cyc(20);
        rst_n = 1;
        expq.push_back(2'b00);
        cyc(420);
        uv = uv_in_t'(3'b001 << (xs() % 3));
        cyc(200 + xs() % 120);
        uv = '0;
        cyc(60);
        $display("test power-up and glitch done");
        press(5 + xs() % 10);
        cyc(8);
        press(2);
        expq.push_back(2'b01);
        expq.push_back(2'b00);
        cyc(2600);
        pb_oe = 0;
        pb_n = 0;
        cyc(200);
        pb_n = 1;
        pb_oe = 1;
        $display("test short press done");
        pb_n = 0;
        expq.push_back(2'b10);
        cyc(LNG + 40);
        pb_n = 1;
        expq.push_back(2'b00);
        cyc(RPD + 40);
        $display("test long press done");
        uv.low_rail_uv = 1;
        expq.push_back(2'b10);
        cyc(340);
        press(10);
        cyc(DEB + 10);
        pb_n = 0;
        uv = '0;
        cyc(400);
        pb_n = 1;
        expq.push_back(2'b00);
        cyc(RPD + 40);
        $display("test supply and button done");
        for (int i = 0; i < 8; i++) begin
            strap = strap_in_t'(i[1:0]);
            uv = i[2] ? uv_in_t'(3'b010) : uv_in_t'(3'b100);
            if (!(strap.rails_match && (strap.above_override ? i[2] : !i[2]))) begin
                expq.push_back(2'b10);
                expq.push_back(2'b00);
            end
            cyc(340);
            uv = '0;
            cyc(325 + RPD + 20);
        end
        $display("test strap override done");
        ce = 0;
        uv = uv_in_t'(3'b001 << (xs() % 3));
        press(LNG + 40);
        uv = '0;
        ce = 1;
        cyc(10);
        $display("test clock enable done");
        check("soft count", 2'(soft_seen), 2'd1);
        test_done();
    end
endmodule : tb_supply_and_pushbutton_reset
bind supply_and_pushbutton_reset rst_seq_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_PRESS_CYC(LONG_PRESS_CYC),
    .RESET_CYC(RESET_CYC)) chk_u (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .UV_IN(UV_IN), .STRAP_IN(STRAP_IN),
    .PUSHBUTTON_IN_N(PUSHBUTTON_IN_N), .PUSHBUTTON_IN_OE(PUSHBUTTON_IN_OE), .RESET_LINE_IN_N(RESET_LINE_IN_N),
    .RESET_OUT(RESET_OUT), .RESET_OUT_N_OE(RESET_OUT_N_OE), .SOFT_RESET_OUT_N_OE(SOFT_RESET_OUT_N_OE));
`default_nettype wire
